// file: rtl/sax_pkg.sv
// Package of constants and types for the receiver auxiliary bit capture block
`default_nettype none
package sax_pkg;

	// ************************************************
	// Register indices; byte address is four times the index
	// ************************************************
	localparam logic [15:0] SAX_IDX_TDM_CTRL = 16'hf608;
	localparam logic [15:0] SAX_IDX_BLOCK_READY = 16'hf60f;
	localparam logic [15:0] SAX_IDX_CHSTAT_LEFT = 16'hf610;
	localparam logic [15:0] SAX_IDX_CHSTAT_RIGHT = 16'hf620;
	localparam logic [15:0] SAX_IDX_USER_LEFT = 16'hf630;
	localparam logic [15:0] SAX_IDX_USER_RIGHT = 16'hf640;
	localparam logic [15:0] SAX_IDX_VALID_LEFT = 16'hf650;
	localparam logic [15:0] SAX_IDX_VALID_RIGHT = 16'hf660;
	localparam logic [15:0] SAX_IDX_PARITY_LEFT = 16'hf670;
	localparam logic [15:0] SAX_IDX_PARITY_RIGHT = 16'hf680;
	localparam logic [15:0] SAX_IDX_IRQ_STATUS = 16'hf6f0;
	localparam logic [15:0] SAX_IDX_IRQ_CLEAR = 16'hf6f1;
	localparam logic [15:0] SAX_IDX_IRQ_ENABLE = 16'hf6f2;
	localparam int SAX_ADDR_W = 18;

	// ************************************************
	// Geometry, field positions and reset values
	// ************************************************
	localparam int SAX_BANKS = 8;
	localparam int SAX_WORDS = 12;
	localparam int SAX_WORD_W = 16;
	localparam int SAX_FRAMES = 192;
	localparam logic [7:0] SAX_LAST_FRAME = 8'hbf;
	localparam logic [3:0] SAX_LAST_WORD = 4'hb;
	localparam int SAX_READY_BIT = 0;
	localparam int SAX_IRQ_DONE_BIT = 0;
	localparam int SAX_IRQ_RESYNC_BIT = 1;
	localparam int SAX_IRQ_W = 2;
	localparam logic [3:0] SAX_SEL_RESET = 4'h0;
	localparam logic [15:0] SAX_BANK_RESET = 16'h0000;
	localparam int SAX_PORTS = 4;
	localparam int SAX_TDM_SLOTS = 8;
	localparam int SAX_SLOT_W = 32;
	localparam int SAX_TDM_BITS = 256;
	localparam logic [7:0] SAX_TDM_LAST = 8'hff;

	// ************************************************
	// AXI4-Lite answers
	// ************************************************
	localparam logic [1:0] SAX_RESP_OKAY = 2'h0;
	localparam logic [1:0] SAX_RESP_SLVERR = 2'h2;

	// ************************************************
	// One decoded frame from the receiver decoder
	// ************************************************
	// aux: 0 cs left, 1 cs right, 2 user left, 3 user right,
	// 4 validity left, 5 validity right, 6 parity left, 7 parity right
	typedef struct packed {
		logic [23:0] audio_l;
		logic [23:0] audio_r;
		logic [7:0] aux;
		logic block_start;
		logic comp_type;
		logic audio_type;
	} sax_frame_t;

endpackage
`default_nettype wire

// file: rtl/sax_tdm_ser.sv
// Eight slot TDM serializer for the decoded audio and auxiliary bits
`default_nettype none
module sax_tdm_ser
	import sax_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic bclk_fall,
	input wire logic fsync_lvl,
	input wire sax_frame_t frame,
	output logic sdata
);

	// ************************************************
	// Slot assembly
	// ************************************************
	// Audio slots 0 and 4 carry 24 bits left justified, other slots at most 4 bits; every slot ends in eight zeros
	wire logic [SAX_TDM_BITS-1:0] tdm_word;
	assign tdm_word = {
		frame.audio_l, 8'h00,
		20'h00000, frame.aux[6], frame.aux[4], frame.aux[2], frame.aux[0], 8'h00,
		22'h000000, frame.comp_type, frame.audio_type, 8'h00,
		32'h00000000,
		frame.audio_r, 8'h00,
		20'h00000, frame.aux[7], frame.aux[5], frame.aux[3], frame.aux[1], 8'h00,
		32'h00000000,
		23'h000000, frame.block_start, 8'h00};

	logic [SAX_TDM_BITS-1:0] shift_q;
	logic fsync_prev_q;
	wire logic frame_edge;
	assign frame_edge = fsync_lvl & ~fsync_prev_q;

	// ************************************************
	// Shifter, MSB first, advanced on falling bit clock
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			shift_q <= '0;
			fsync_prev_q <= 1'b0;
		end else if (ce && bclk_fall) begin
			fsync_prev_q <= fsync_lvl;
			if (frame_edge) begin
				shift_q <= tdm_word;
			end else begin
				shift_q <= {shift_q[SAX_TDM_BITS-2:0], 1'b0};
			end
		end
	end

	// Output bit of the current slot
	assign sdata = shift_q[SAX_TDM_BITS-1];

endmodule
`default_nettype wire

// file: rtl/sax_capture.sv
// Receiver auxiliary bit capture banks with AXI4-Lite registers and TDM routing
`default_nettype none
module sax_capture
	import sax_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	// Decoded frames from the receiver decoder
	input wire logic frame_valid,
	input wire sax_frame_t frame_in,
	// Serial port clocks, port in master mode
	input wire logic tdm_bclk_pin,
	input wire logic tdm_fsync_pin,
	output logic [SAX_PORTS-1:0] serial_data_out_pin,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [SAX_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [SAX_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ************************************************
	// State
	// ************************************************
	logic [SAX_FRAMES-1:0] shadow_q [SAX_BANKS];
	logic [SAX_FRAMES-1:0] vis_q [SAX_BANKS];
	logic [7:0] frame_cnt_q;
	logic locked_q;
	logic ready_q;
	logic [3:0] port_sel_q;
	logic [SAX_IRQ_W-1:0] irq_stat_q;
	logic [SAX_IRQ_W-1:0] irq_en_q;
	logic irq_q;
	sax_frame_t tdm_frame_q;
	logic [SAX_PORTS-1:0] sdo_q;
	logic [2:0] bclk_sync_q;
	logic [1:0] fsync_sync_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_hold_q, w_hold_q;
	logic [15:0] wr_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// ************************************************
	// Frame capture control
	// ************************************************
	// A block start always restarts the count; frames before the first one are dropped
	wire logic take_frame;
	wire logic [7:0] slot_idx;
	wire logic block_done;
	wire logic resync;
	assign take_frame = ce & frame_valid & (locked_q | frame_in.block_start);
	assign slot_idx = frame_in.block_start ? 8'h00 : frame_cnt_q;
	assign block_done = take_frame & (slot_idx == SAX_LAST_FRAME);
	assign resync = ce & frame_valid & frame_in.block_start & locked_q & (frame_cnt_q != 8'h00);

	// Frame counter and lock
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			frame_cnt_q <= 8'h00;
			locked_q <= 1'b0;
		end else if (take_frame) begin
			locked_q <= 1'b1;
			frame_cnt_q <= block_done ? 8'h00 : slot_idx + 8'h01;
		end
	end

	// Ready flag, set once and held; nothing software does clears it
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ready_q <= 1'b0;
		end else if (block_done) begin
			ready_q <= 1'b1;
		end
	end

	// ************************************************
	// Shadow and visible banks
	// ************************************************
	// Shadow fills during a block; visible banks change only when a block completes,
	// so software never reads a half old, half new block
	for (genvar b = 0; b < SAX_BANKS; b++) begin : g_bank
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				shadow_q[b] <= '0;
				vis_q[b] <= '0;
			end else if (take_frame) begin
				shadow_q[b][slot_idx] <= frame_in.aux[b];
				if (block_done) begin
					vis_q[b] <= {frame_in.aux[b], shadow_q[b][SAX_FRAMES-2:0]};
				end
			end
		end
	end

	// ************************************************
	// TDM routing
	// ************************************************
	// Only a single set bit routes the stream; anything else keeps all outputs quiet
	wire logic sel_onehot;
	wire logic [SAX_PORTS-1:0] port_en;
	wire logic bclk_fall;
	wire logic tdm_bit;
	assign sel_onehot = (port_sel_q != 4'h0) & ((port_sel_q & (port_sel_q - 4'h1)) == 4'h0);
	assign port_en = sel_onehot ? port_sel_q : 4'h0;
	assign bclk_fall = bclk_sync_q[2] & ~bclk_sync_q[1];

	// Pin synchronisers; edge detect looks only past the first stage
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bclk_sync_q <= 3'h0;
			fsync_sync_q <= 2'h0;
		end else if (ce) begin
			bclk_sync_q <= {bclk_sync_q[1:0], tdm_bclk_pin};
			fsync_sync_q <= {fsync_sync_q[0], tdm_fsync_pin};
		end
	end

	// Latest decoded frame for the TDM stream
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tdm_frame_q <= '0;
		end else if (ce && frame_valid) begin
			tdm_frame_q <= frame_in;
		end
	end

	sax_tdm_ser u_ser (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.bclk_fall(bclk_fall),
		.fsync_lvl(fsync_sync_q[1]),
		.frame(tdm_frame_q),
		.sdata(tdm_bit)
	);

	// Output pins registered, only the selected one toggles
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sdo_q <= 4'h0;
		end else if (ce) begin
			sdo_q <= port_en & {SAX_PORTS{tdm_bit}};
		end
	end

	// ************************************************
	// Bus decode
	// ************************************************
	wire logic aw_take, w_take, ar_take, wr_go;
	wire logic [15:0] rd_idx;
	wire logic rd_bank_hit, wr_bank_hit;
	wire logic [2:0] rd_bank;
	wire logic [3:0] rd_word;
	wire logic [SAX_WORD_W-1:0] rd_bank_word;
	wire logic rd_ctrl, rd_ready, rd_stat, rd_clr, rd_en, rd_hit;
	wire logic wr_ctrl, wr_clr, wr_en, wr_ro, wr_hit;
	assign aw_take = ce & s_axi_awvalid & awready_q;
	assign w_take = ce & s_axi_wvalid & wready_q;
	assign ar_take = ce & s_axi_arvalid & arready_q;
	assign wr_go = ce & aw_hold_q & w_hold_q & ~bvalid_q;
	assign rd_idx = s_axi_araddr[SAX_ADDR_W-1:2];
	assign rd_bank_hit = (rd_idx[15:8] == 8'hf6) & (rd_idx[7:4] >= 4'h1) & (rd_idx[7:4] <= 4'h8)
		& (rd_idx[3:0] <= SAX_LAST_WORD);
	assign wr_bank_hit = (wr_idx_q[15:8] == 8'hf6) & (wr_idx_q[7:4] >= 4'h1) & (wr_idx_q[7:4] <= 4'h8)
		& (wr_idx_q[3:0] <= SAX_LAST_WORD);
	assign rd_bank = 3'(rd_idx[7:4] - 4'h1);
	assign rd_word = rd_idx[3:0];
	assign rd_bank_word = vis_q[rd_bank][rd_word*SAX_WORD_W +: SAX_WORD_W];
	assign rd_ctrl = rd_idx == SAX_IDX_TDM_CTRL;
	assign rd_ready = rd_idx == SAX_IDX_BLOCK_READY;
	assign rd_stat = rd_idx == SAX_IDX_IRQ_STATUS;
	assign rd_clr = rd_idx == SAX_IDX_IRQ_CLEAR;
	assign rd_en = rd_idx == SAX_IDX_IRQ_ENABLE;
	assign rd_hit = rd_bank_hit | rd_ctrl | rd_ready | rd_stat | rd_clr | rd_en;
	assign wr_ctrl = wr_idx_q == SAX_IDX_TDM_CTRL;
	assign wr_clr = wr_idx_q == SAX_IDX_IRQ_CLEAR;
	assign wr_en = wr_idx_q == SAX_IDX_IRQ_ENABLE;
	assign wr_ro = wr_bank_hit | (wr_idx_q == SAX_IDX_BLOCK_READY) | (wr_idx_q == SAX_IDX_IRQ_STATUS);
	assign wr_hit = wr_ctrl | wr_clr | wr_en | wr_ro;

	// Read data; reserved bits and the write-only clear register read zero
	wire logic [31:0] rd_mux;
	assign rd_mux = rd_bank_hit ? {16'h0000, rd_bank_word}
		: rd_ctrl ? {28'h0000000, port_sel_q}
		: rd_ready ? {31'h00000000, ready_q}
		: rd_stat ? {30'h00000000, irq_stat_q}
		: rd_en ? {30'h00000000, irq_en_q}
		: 32'h00000000;

	// ************************************************
	// Write channels
	// ************************************************
	// Address and data are taken in either order; response once both are held
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			wr_idx_q <= 16'h0000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= SAX_RESP_OKAY;
		end else if (ce) begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_hold_q <= 1'b1;
				wr_idx_q <= s_axi_awaddr[SAX_ADDR_W-1:2];
			end
			if (w_take) begin
				wready_q <= 1'b0;
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? SAX_RESP_OKAY : SAX_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Writable registers; read-only targets are acknowledged and ignored
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_sel_q <= SAX_SEL_RESET;
			irq_en_q <= '0;
		end else if (wr_go && wstrb_q[0]) begin
			if (wr_ctrl) begin
				port_sel_q <= wdata_q[3:0];
			end
			if (wr_en) begin
				irq_en_q <= wdata_q[SAX_IRQ_W-1:0];
			end
		end
	end

	// ************************************************
	// Interrupts
	// ************************************************
	// A new event in the clearing cycle wins over the clear
	wire logic [SAX_IRQ_W-1:0] irq_evt;
	wire logic [SAX_IRQ_W-1:0] irq_clr;
	assign irq_evt = {resync, block_done};
	assign irq_clr = (wr_go && wstrb_q[0] && wr_clr) ? wdata_q[SAX_IRQ_W-1:0] : '0;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_stat_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	// ************************************************
	// Read channel
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= SAX_RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? SAX_RESP_OKAY : SAX_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// Outputs straight from flops
	assign serial_data_out_pin = sdo_q;
	assign irq = irq_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ************************************************
	// Checks
	// ************************************************
	chk_ready_on_done: assert property (@(posedge clk_sys) disable iff (reset)
		block_done |=> ready_q) else $error("ready flag not set after last frame");
	chk_ready_no_fall: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(ready_q) |-> 1'b0) else $error("ready flag fell without reset");
	chk_ready_cause: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(ready_q) |-> $past(block_done)) else $error("ready flag rose without a full block");
	chk_rsvd_read_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(ar_take && rd_ready) |=> (s_axi_rdata[31:1] == 31'h00000000 && s_axi_rdata[0] == $past(ready_q)))
		else $error("ready register read wrong");
	chk_vis_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!block_done |=> $stable(vis_q[0]) && $stable(vis_q[5]) && $stable(vis_q[7]))
		else $error("visible bank changed outside block completion");
	chk_bit_store: assert property (@(posedge clk_sys) disable iff (reset)
		(take_frame && !block_done && slot_idx == 8'h11) |=> shadow_q[2][17] == $past(frame_in.aux[2]))
		else $error("frame bit stored at wrong position");
	chk_count_next: assert property (@(posedge clk_sys) disable iff (reset)
		(take_frame && !block_done) |=> frame_cnt_q == $past(slot_idx) + 8'h01)
		else $error("frame counter did not advance");
	chk_port_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && !sel_onehot) |=> serial_data_out_pin == 4'h0) else $error("output active while disabled");
	chk_port_route: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && port_sel_q == 4'h1) |=> serial_data_out_pin == {3'h0, $past(tdm_bit)})
		else $error("stream not on output 0");
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && (irq_stat_q & irq_en_q) != '0) |=> irq) else $error("interrupt not raised");

endmodule
`default_nettype wire

// file: sim/sax_decoder_model.sv
// Behavioural receiver decoder: frame pulses and master TDM clocks
`default_nettype none
module sax_decoder_model
	import sax_pkg::*;
(
	input wire logic clk_sys,
	output logic frame_valid,
	output sax_frame_t frame_in,
	output logic tdm_bclk_pin,
	output logic tdm_fsync_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels at time zero
	initial begin
		frame_valid = 1'b0;
		frame_in = '0;
		tdm_bclk_pin = 1'b0;
		tdm_fsync_pin = 1'b0;
	end

	// Back to back frames; frame n carries n in its aux bits, frame 0 opens the block
	task automatic send_frames(input int first, input int count);
		sax_frame_t f;
		f = '0;
		for (int n = first; n < first + count; n++) begin
			f = '0;
			f.audio_l = 24'ha5a5a5;
			f.audio_r = 24'h5a5a5a;
			f.aux = n[7:0];
			f.block_start = (n == 0);
			frame_valid <= 1'b1;
			frame_in <= f;
			@(posedge clk_sys);
		end
		frame_valid <= 1'b0;
		frame_in <= ~f; // Stale data is not left on the bus
		@(posedge clk_sys);
	endtask

	// Port runs as clock master; bclk stands low between frames
	task automatic tdm_frame();
		tdm_fsync_pin <= 1'b1;
		for (int b = 0; b < SAX_TDM_BITS + 2; b++) begin
			tdm_bclk_pin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			tdm_bclk_pin <= 1'b0;
			repeat (4) @(posedge clk_sys);
			tdm_fsync_pin <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// file: sim/test_sax_capture.sv
// Self-checking bench for the auxiliary bit capture block
`default_nettype none
module test_sax_capture
	import sax_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [3:0] SEL_TAB [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h3};
	// Stream of the last frame taken: audio a5a5a5/5a5a5a, aux bits 0xbf, no block start
	localparam logic [SAX_TDM_BITS-1:0] TDM_EXP = {32'ha5a5a500, 32'h00000700, 64'h0, 32'h5a5a5a00, 32'h00000f00,
		64'h0};
	logic clk_sys, reset, ce, frame_valid, tdm_bclk_pin, tdm_fsync_pin, irq;
	sax_frame_t frame_in;
	logic [SAX_PORTS-1:0] serial_data_out_pin;
	logic [SAX_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors = 0;
	int tests_run = 0;

	sax_capture sax_capture_inst (.clk_sys(clk_sys), .reset(reset), .ce(ce), .frame_valid(frame_valid),
		.frame_in(frame_in), .tdm_bclk_pin(tdm_bclk_pin), .tdm_fsync_pin(tdm_fsync_pin),
		.serial_data_out_pin(serial_data_out_pin), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	sax_decoder_model sax_decoder_model_inst (.clk_sys(clk_sys), .frame_valid(frame_valid),
		.frame_in(frame_in), .tdm_bclk_pin(tdm_bclk_pin), .tdm_fsync_pin(tdm_fsync_pin));

	// ************************************************
	// Reporting and bus helpers
	// ************************************************
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Write: address and data offered together, bready held until bvalid
	task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		if (s_axi_bvalid !== 1'b1) begin
			num_errors++;
			conclude();
		end
		check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Read with rready held until rvalid, then judge data and response
	task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		if (s_axi_rvalid !== 1'b1) begin
			num_errors++;
			conclude();
		end
		check(what, exp, s_axi_rdata);
		check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	function automatic logic [15:0] bank_idx(input int b, input int w);
		bank_idx = SAX_IDX_CHSTAT_LEFT + 16'(b * 16 + w);
	endfunction

	// Frame n carries n in its aux bits, so bank b bit i of word w is bit b of 16w+i
	function automatic logic [15:0] bank_exp(input int b, input int w);
		logic [7:0] n;
		bank_exp = '0;
		for (int i = 0; i < 16; i++) begin
			n = 8'(w * 16 + i);
			bank_exp[i] = n[b];
		end
	endfunction

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_reset();
		rd_chk("ready", SAX_IDX_BLOCK_READY, 32'h0, SAX_RESP_OKAY);
		rd_chk("port_sel", SAX_IDX_TDM_CTRL, 32'h0, SAX_RESP_OKAY);
		for (int b = 0; b < SAX_BANKS; b++) begin
			for (int w = 0; w < SAX_WORDS; w++) begin
				rd_chk($sformatf("bank%0d_%0d", b, w), bank_idx(b, w), 32'h0, SAX_RESP_OKAY);
			end
		end
		check("irq_reset", 32'h0, {31'h0, irq});
	endtask

	task automatic t_access();
		axi_wr(SAX_IDX_BLOCK_READY, 32'hffff, SAX_RESP_OKAY);
		axi_wr(bank_idx(5, 11), 32'hffff, SAX_RESP_OKAY);
		rd_chk("ready_wr", SAX_IDX_BLOCK_READY, 32'h0, SAX_RESP_OKAY);
		rd_chk("bank_wr", bank_idx(5, 11), 32'h0, SAX_RESP_OKAY);
		axi_wr(16'hf700, 32'h1, SAX_RESP_SLVERR);
		rd_chk("unmapped", 16'hf700, 32'h0, SAX_RESP_SLVERR);
	endtask

	// Aborted block, restart, then full block with ready flag and interrupt
	task automatic t_block();
		axi_wr(SAX_IDX_IRQ_ENABLE, 32'h1, SAX_RESP_OKAY);
		sax_decoder_model_inst.send_frames(0, 5);
		sax_decoder_model_inst.send_frames(0, SAX_FRAMES - 1);
		// Frame offered with the clock enable low must not complete the block
		ce <= 1'b0;
		sax_decoder_model_inst.send_frames(5, 1);
		ce <= 1'b1;
		rd_chk("ready_early", SAX_IDX_BLOCK_READY, 32'h0, SAX_RESP_OKAY);
		rd_chk("status_resync", SAX_IDX_IRQ_STATUS, 32'h2, SAX_RESP_OKAY);
		check("irq_masked", 32'h0, {31'h0, irq});
		sax_decoder_model_inst.send_frames(SAX_FRAMES - 1, 1);
		rd_chk("ready_done", SAX_IDX_BLOCK_READY, 32'h1, SAX_RESP_OKAY);
		rd_chk("status_done", SAX_IDX_IRQ_STATUS, 32'h3, SAX_RESP_OKAY);
		check("irq_done", 32'h1, {31'h0, irq});
		for (int b = 0; b < SAX_BANKS; b++) begin
			for (int w = 0; w < SAX_WORDS; w++) begin
				rd_chk($sformatf("cap%0d_%0d", b, w), bank_idx(b, w), {16'h0, bank_exp(b, w)}, SAX_RESP_OKAY);
			end
		end
		axi_wr(SAX_IDX_IRQ_ENABLE, 32'h0, SAX_RESP_OKAY);
		check("irq_off", 32'h0, {31'h0, irq});
		axi_wr(SAX_IDX_IRQ_CLEAR, 32'h3, SAX_RESP_OKAY);
		rd_chk("status_clr", SAX_IDX_IRQ_STATUS, 32'h0, SAX_RESP_OKAY);
		axi_wr(SAX_IDX_IRQ_ENABLE, 32'h1, SAX_RESP_OKAY);
		check("irq_clr", 32'h0, {31'h0, irq});
		rd_chk("ready_kept", SAX_IDX_BLOCK_READY, 32'h1, SAX_RESP_OKAY);
	endtask

	// Six select codes, one TDM frame each; only a one-hot code may drive its pin
	task automatic t_tdm();
		logic [3:0] seen;
		logic [3:0] exp;
		logic [SAX_TDM_BITS-1:0] stream;
		logic [31:0] slot_exp;
		for (int k = 0; k < 6; k++) begin
			exp = $onehot(SEL_TAB[k]) ? SEL_TAB[k] : 4'h0;
			axi_wr(SAX_IDX_TDM_CTRL, {28'h0, SEL_TAB[k]}, SAX_RESP_OKAY);
			rd_chk("port_sel", SAX_IDX_TDM_CTRL, {28'h0, SEL_TAB[k]}, SAX_RESP_OKAY);
			seen = 4'h0;
			stream = '0;
			fork
				sax_decoder_model_inst.tdm_frame();
				// Bit j stands on its pin from cycle 8j+8 to 8j+16 of the frame; sampled mid-bit
				for (int c = 1; c <= 2200; c++) begin
					@(posedge clk_sys);
					seen = seen | serial_data_out_pin;
					if (c % 8 == 4 && c >= 12 && c <= 2052) begin
						stream = {stream[SAX_TDM_BITS-2:0], |(serial_data_out_pin & exp)};
					end
				end
			join
			check("tdm_pins", {28'h0, exp}, {28'h0, seen});
			for (int s = 0; s < SAX_TDM_SLOTS; s++) begin
				slot_exp = (exp != 4'h0) ? TDM_EXP[SAX_TDM_BITS-1-SAX_SLOT_W*s -: SAX_SLOT_W] : 32'h0;
				check($sformatf("tdm_slot%0d", s), slot_exp, stream[SAX_TDM_BITS-1-SAX_SLOT_W*s -: SAX_SLOT_W]);
			end
		end
	endtask

	// Reset in mid-run drops the ready flag and empties the banks
	task automatic t_rerun();
		reset <= 1'b1;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd_chk("ready_rst", SAX_IDX_BLOCK_READY, 32'h0, SAX_RESP_OKAY);
		rd_chk("bank_rst", bank_idx(7, 11), 32'h0, SAX_RESP_OKAY);
	endtask

	// ************************************************
	// Clock, reset and main sequence
	// ************************************************
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_access();
		t_block();
		t_tdm();
		t_rerun();
		conclude();
	end
endmodule
`default_nettype wire
